// [shared/lcd_cfg.svh]
// Constants of the LCD column driver host port
`ifndef LCD_CFG_SVH
`define LCD_CFG_SVH
`define LCD_ONOFF_CODE 7'h1F
`define LCD_PAGE_CODE 5'h17
`define LCD_COL_CODE 2'h1
`define LCD_LINE_CODE 2'h3
`define LCD_BUSY_CYC 4'h3
`define LCD_LINE_RST 6'h00
`define LCD_COL_RST 6'h00
`define LCD_PAGE_RST 3'h0
`define LCD_COL_LAST 6'h3F
`define LCD_COL_STEP 6'h01
`define LCD_ROW_STEP 6'h01
`define LCD_CNT_STEP 4'h1
`define LCD_CNT_ZERO 4'h0
`define LCD_BYTE_ZERO 8'h00
`define LCD_NIBBLE_ZERO 4'h0
`endif

// [shared/lcd_pkg.sv]
// Types of the LCD column driver host port
`default_nettype none
package lcd_pkg;
  typedef enum logic [1:0] {
    LCD_ACC_INSTR,
    LCD_ACC_STATUS,
    LCD_ACC_WDATA,
    LCD_ACC_RDATA
  } lcd_access_type;
  typedef enum {
    LCD_IDLE,
    LCD_WRITE,
    LCD_READ,
    LCD_BUSY
  } lcd_state_type;
endpackage : lcd_pkg
`default_nettype wire

// [hw/lcd_col_drv.sv]
// LCD column driver host port, display memory and segment latch
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cfg.svh"
module lcd_col_drv #(
  parameter int COL_NUM = 64,
  parameter int PAGE_NUM = 8
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // Host bus
  input wire logic chip_select_first_low_n_in,
  input wire logic chip_select_second_low_n_in,
  input wire logic chip_select_third_high_in,
  input wire logic register_select_in,
  input wire logic read_write_in,
  input wire logic strobe_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  // Device pins
  input wire logic reset_input_low_n_in,
  input wire logic segment_order_in,
  // Display timing
  input wire logic line_shift_pulse_in,
  input wire logic frame_sync_in,
  // Segment drive
  output logic [63:0] segment_out,
  output logic [5:0] row_out
);

  if (COL_NUM != 64 || PAGE_NUM != 8) begin : g_bad_param
    $error("lcd_col_drv serves only 64 columns and 8 pages");
  end

  // Display memory, page in upper address bits
  logic [7:0] display_memory [0:511];

  // Control state
  lcd_pkg::lcd_state_type state_reg;
  lcd_pkg::lcd_state_type state_next;
  logic [3:0] busy_cnt_reg;
  logic [3:0] busy_cnt_next;
  logic strobe_prev_reg;
  logic lsp_prev_reg;
  logic [7:0] input_reg;
  logic [7:0] output_reg;
  logic [2:0] page_reg;
  logic [5:0] col_reg;
  logic [5:0] col_next;
  logic [5:0] start_line_reg;
  logic [5:0] row_reg;
  logic off_pend_reg;
  logic off_reg;
  logic in_reset_reg;
  logic [7:0] data_out_reg;
  logic data_oe_reg;
  logic [63:0] segment_reg;

  // Bus decode
  wire chip_sel = ~chip_select_first_low_n_in
                & ~chip_select_second_low_n_in
                & chip_select_third_high_in;
  wire strobe_fall = strobe_prev_reg & ~strobe_in;
  wire access = chip_sel & strobe_fall;
  wire [1:0] acc_code = {register_select_in, read_write_in};
  lcd_pkg::lcd_access_type acc_kind;
  assign acc_kind = lcd_pkg::lcd_access_type'(acc_code);
  wire busy = (state_reg != lcd_pkg::LCD_IDLE);
  wire in_reset = ~reset_input_low_n_in;
  wire accept = access & ~busy & ~in_reset;
  wire acc_instr = accept & (acc_kind == lcd_pkg::LCD_ACC_INSTR);
  wire acc_wdata = accept & (acc_kind == lcd_pkg::LCD_ACC_WDATA);
  wire acc_rdata = accept & (acc_kind == lcd_pkg::LCD_ACC_RDATA);
  wire bus_read = chip_sel & strobe_in & read_write_in;

  // Instruction decode
  wire is_onoff = (data_in[7:1] == `LCD_ONOFF_CODE);
  wire is_page = (data_in[7:3] == `LCD_PAGE_CODE);
  wire is_col = (data_in[7:6] == `LCD_COL_CODE);
  wire is_line = (data_in[7:6] == `LCD_LINE_CODE);
  wire do_onoff = acc_instr & is_onoff;
  wire do_page = acc_instr & is_page;
  wire do_col = acc_instr & is_col;
  wire do_line = acc_instr & is_line;

  // Status byte
  wire [7:0] status_byte = {busy, 1'b0, off_reg, in_reset_reg,
                            `LCD_NIBBLE_ZERO};
  wire [7:0] bus_byte = register_select_in ? output_reg
                                           : status_byte;

  // Memory addressing
  wire [8:0] mem_addr = {page_reg, col_reg};
  wire col_step = (state_reg == lcd_pkg::LCD_WRITE)
                | (state_reg == lcd_pkg::LCD_READ);
  wire [5:0] col_inc = (col_reg == `LCD_COL_LAST) ? `LCD_COL_RST
                     : col_reg + `LCD_COL_STEP;

  // Display timing
  wire lsp_rise = line_shift_pulse_in & ~lsp_prev_reg;
  wire [5:0] row_inc = row_reg + `LCD_ROW_STEP;
  wire blank = off_reg | in_reset;

  // Row bits of every column for the current row
  logic [63:0] row_bits;
  logic [63:0] segment_next;
  for (genvar c = 0; c < 64; c++) begin : g_col
    wire [8:0] rd_addr = {row_reg[5:3], 6'(c)};
    wire [7:0] rd_byte = display_memory[rd_addr];
    assign row_bits[c] = rd_byte[row_reg[2:0]];
    assign segment_next[c] = ~blank & (segment_order_in
                           ? row_bits[c]
                           : row_bits[63 - c]);
  end

  // Sequencer of accepted accesses
  always_comb begin
    state_next = state_reg;
    busy_cnt_next = busy_cnt_reg;
    unique case (state_reg)
      lcd_pkg::LCD_IDLE: begin
        busy_cnt_next = `LCD_BUSY_CYC;
        if (acc_wdata) begin
          state_next = lcd_pkg::LCD_WRITE;
        end else if (acc_rdata) begin
          state_next = lcd_pkg::LCD_READ;
        end else if (acc_instr) begin
          state_next = lcd_pkg::LCD_BUSY;
        end
      end
      lcd_pkg::LCD_WRITE: begin
        state_next = lcd_pkg::LCD_BUSY;
      end
      lcd_pkg::LCD_READ: begin
        state_next = lcd_pkg::LCD_BUSY;
      end
      lcd_pkg::LCD_BUSY: begin
        if (busy_cnt_reg == `LCD_CNT_ZERO) begin
          state_next = lcd_pkg::LCD_IDLE;
        end else begin
          busy_cnt_next = busy_cnt_reg - `LCD_CNT_STEP;
        end
      end
    endcase
  end

  // Column counter next value
  always_comb begin
    col_next = col_reg;
    if (do_col) begin
      col_next = data_in[5:0];
    end else if (col_step) begin
      col_next = col_inc;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= lcd_pkg::LCD_IDLE;
      busy_cnt_reg <= `LCD_CNT_ZERO;
    end else begin
      state_reg <= state_next;
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  // Edge history of strobe and line pulse
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strobe_prev_reg <= 1'b0;
      lsp_prev_reg <= 1'b0;
    end else begin
      strobe_prev_reg <= strobe_in;
      lsp_prev_reg <= line_shift_pulse_in;
    end
  end

  // Holding input register
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      input_reg <= `LCD_BYTE_ZERO;
    end else if (acc_wdata) begin
      input_reg <= data_in;
    end
  end

  // Memory store by internal operation
  always_ff @(posedge clock_in) begin
    if (state_reg == lcd_pkg::LCD_WRITE) begin
      display_memory[mem_addr] <= input_reg;
    end
  end

  // Output register loaded by each data read
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      output_reg <= `LCD_BYTE_ZERO;
    end else if (state_reg == lcd_pkg::LCD_READ) begin
      output_reg <= display_memory[mem_addr];
    end
  end

  // Page register and column counter
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      page_reg <= `LCD_PAGE_RST;
      col_reg <= `LCD_COL_RST;
    end else begin
      if (do_page) begin
        page_reg <= data_in[2:0];
      end
      col_reg <= col_next;
    end
  end

  // Start line register
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      start_line_reg <= `LCD_LINE_RST;
    end else if (in_reset) begin
      start_line_reg <= `LCD_LINE_RST;
    end else if (do_line) begin
      start_line_reg <= data_in[5:0];
    end
  end

  // On/off flip-flop, applied at the line pulse
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      off_pend_reg <= 1'b1;
      off_reg <= 1'b1;
    end else if (in_reset) begin
      off_pend_reg <= 1'b1;
      off_reg <= 1'b1;
    end else begin
      if (do_onoff) begin
        off_pend_reg <= ~data_in[0];
      end
      if (lsp_rise) begin
        off_reg <= off_pend_reg;
      end
    end
  end

  // Reset flag seen by status reads
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      in_reset_reg <= 1'b1;
    end else begin
      in_reset_reg <= in_reset;
    end
  end

  // Row counter, preset to the start line while frame sync is high
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      row_reg <= `LCD_LINE_RST;
    end else if (frame_sync_in) begin
      row_reg <= start_line_reg;
    end else if (lsp_rise) begin
      row_reg <= row_inc;
    end
  end

  // Segment latch
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      segment_reg <= '0;
    end else if (lsp_rise | blank) begin
      segment_reg <= segment_next;
    end
  end

  // Read data drive
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      data_out_reg <= `LCD_BYTE_ZERO;
      data_oe_reg <= 1'b0;
    end else begin
      data_out_reg <= bus_byte;
      data_oe_reg <= bus_read;
    end
  end

  assign data_out = data_out_reg;
  assign data_oe_out = data_oe_reg;
  assign segment_out = segment_reg;
  assign row_out = row_reg;

endmodule : lcd_col_drv
`default_nettype wire

// [tb/lcd_col_drv_chk.sv]
// Assertion checker for the LCD column driver host port
`timescale 1ns/1ps
`default_nettype none
module lcd_col_drv_chk #(
  parameter int COL_NUM = 64,
  parameter int PAGE_NUM = 8
) (
  // Clock, reset and host bus
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic chip_select_first_low_n_in,
  input wire logic chip_select_second_low_n_in,
  input wire logic chip_select_third_high_in,
  input wire logic register_select_in,
  input wire logic read_write_in,
  input wire logic strobe_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe_out,
  // Device pins and display side
  input wire logic reset_input_low_n_in,
  input wire logic line_shift_pulse_in,
  input wire logic frame_sync_in,
  input wire logic [63:0] segment_out,
  input wire logic [5:0] row_out
);
  wire logic sel;
  wire logic rd_req;
  assign sel = !chip_select_first_low_n_in && !chip_select_second_low_n_in
    && chip_select_third_high_in;
  assign rd_req = sel && strobe_in && read_write_in;
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!arst_n_in);
  AST_OE_FOLLOWS: assert property (
    data_oe_out == $past(rd_req))
    else $error("bus enable wrong");
  AST_DESELECT_QUIET: assert property (
    !sel |=> !data_oe_out)
    else $error("driven while deselected");
  AST_STATUS_ZEROS: assert property (
    data_oe_out && !$past(register_select_in)
    |-> data_out[6] == 1'b0 && data_out[3:0] == 4'h0)
    else $error("status zero bits set");
  AST_RESET_STATUS: assert property (
    data_oe_out && !$past(register_select_in) && !$past(reset_input_low_n_in)
    && !$past(reset_input_low_n_in, 2) && !$past(reset_input_low_n_in, 3)
    |-> data_out[5:4] == 2'h3)
    else $error("status not off and reset");
  AST_BLANK_IN_RESET: assert property (
    !reset_input_low_n_in [*3] |-> segment_out == 64'h0)
    else $error("segments not blank");
  AST_ROW_PRESET_ZERO: assert property (
    (frame_sync_in && !reset_input_low_n_in) [*3] |-> row_out == 6'h00)
    else $error("start line not zero");
  AST_SEG_ON_LINE: assert property (
    !$stable(segment_out) && !$past(line_shift_pulse_in)
    && !$past(line_shift_pulse_in, 2) && !$past(line_shift_pulse_in, 3)
    |-> segment_out == 64'h0)
    else $error("segments moved off line pulse");
  AST_READ_HOLDS: assert property (
    data_oe_out && $past(data_oe_out) && $past(register_select_in)
    && $past(register_select_in, 2) |-> $stable(data_out))
    else $error("read byte moved");
endmodule : lcd_col_drv_chk
`default_nettype wire

// [tb/lcd_host_mdl.sv]
// Host processor model on the strobed parallel bus
`timescale 1ns/1ps
`default_nettype none
module lcd_host_mdl (
  // Bus to the driver
  input wire logic clock_in,
  input wire logic [7:0] data_in,
  output logic cs_n_out,
  output logic rs_out,
  output logic rw_out,
  output logic stb_out,
  output logic [7:0] data_out
);
  initial begin
    cs_n_out = 1'b1;
    rs_out = 1'b0;
    rw_out = 1'b0;
    stb_out = 1'b0;
    data_out = 8'h00;
  end
  task automatic acc(input logic sel, input logic rs, input logic rw,
    input logic [7:0] d, output logic [7:0] q);
    @(negedge clock_in);
    cs_n_out = ~sel;
    rs_out = rs;
    rw_out = rw;
    data_out = rw ? ~data_out : d;
    stb_out = 1'b1;
    repeat (3) @(negedge clock_in);
    q = data_in;
    stb_out = 1'b0;
    repeat (2) @(negedge clock_in);
    cs_n_out = 1'b1;
  endtask : acc
  task automatic poll(output logic [7:0] st);
    st = 8'hFF;
    for (int i = 0; i < 20 && (st[7] || st[4]); i++) begin
      acc(1'b1, 1'b0, 1'b1, 8'h00, st);
    end
  endtask : poll
endmodule : lcd_host_mdl
`default_nettype wire

// [tb/lcd_column_driver_host_port_bench.sv]
// Testbench of the LCD column driver host port
`timescale 1ns/1ps
`default_nettype none
module lcd_column_driver_host_port_bench;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic pin_n = 1'b0;
  logic lsp = 1'b0;
  logic frame_sync = 1'b0;
  logic seg_order = 1'b1;
  logic cs2_n = 1'b0;
  logic cs3 = 1'b1;
  logic cs_n, rs, rw, stb, oe;
  logic [7:0] din, dout, q, st;
  logic [63:0] seg;
  logic [5:0] row;
  logic [7:0] exp_rd [3] = '{8'hA5, 8'h5A, 8'hC3};
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  always #5 clock_in = ~clock_in;
  lcd_col_drv uut (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .chip_select_first_low_n_in(cs_n), .chip_select_second_low_n_in(cs2_n),
    .chip_select_third_high_in(cs3), .register_select_in(rs),
    .read_write_in(rw), .strobe_in(stb), .data_in(din), .data_out(dout),
    .data_oe_out(oe), .reset_input_low_n_in(pin_n),
    .segment_order_in(seg_order),
    .line_shift_pulse_in(lsp), .frame_sync_in(frame_sync), .segment_out(seg),
    .row_out(row));
  lcd_host_mdl host (.clock_in(clock_in), .data_in(dout), .cs_n_out(cs_n),
    .rs_out(rs), .rw_out(rw), .stb_out(stb), .data_out(din));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic cmd(input logic r, input logic [7:0] d);
    host.acc(1'b1, r, 1'b0, d, q);
    host.poll(st);
  endtask : cmd
  task automatic rd(input logic r);
    host.acc(1'b1, r, 1'b1, 8'h00, q);
    host.poll(st);
  endtask : rd
  task automatic pulse(input logic line, input logic [7:0] e);
    if (line) begin
      lsp = 1'b1;
    end else begin
      frame_sync = 1'b1;
    end
    repeat (3) @(negedge clock_in);
    chk("row", e, {2'h0, row});
    lsp = 1'b0;
    frame_sync = 1'b0;
    repeat (2) @(negedge clock_in);
  endtask : pulse
  task automatic end_of_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(negedge clock_in);
    arst_n_in = 1'b1;
    repeat (2) @(negedge clock_in);
    host.acc(1'b1, 1'b0, 1'b1, 8'h00, q);
    chk("status", 8'h30, q);
    host.acc(1'b1, 1'b0, 1'b0, 8'hC5, q);
    frame_sync = 1'b1;
    repeat (4) @(negedge clock_in);
    chk("row", 8'h00, {2'h0, row});
    frame_sync = 1'b0;
    pin_n = 1'b1;
    host.poll(q);
    chk("status", 8'h20, q);
    cmd(1'b0, 8'hD8);
    pulse(1'b0, 8'h18);
    cmd(1'b0, 8'hBB);
    cmd(1'b0, 8'h7E);
    host.acc(1'b1, 1'b1, 1'b0, 8'hA5, q);
    host.acc(1'b1, 1'b0, 1'b1, 8'h00, q);
    chk("busy", 8'hA0, q);
    host.poll(st);
    cmd(1'b1, 8'h5A);
    cmd(1'b1, 8'hC3);
    cmd(1'b0, 8'hBC);
    cmd(1'b0, 8'h7E);
    cmd(1'b1, 8'hFF);
    for (int j = 0; j < 3; j++) begin
      cs2_n = (j == 1);
      cs3 = (j != 2);
      host.acc(j != 0, 1'b1, 1'b0, 8'h11, q);
      cs2_n = 1'b0;
      cs3 = 1'b1;
      host.acc(1'b1, 1'b0, 1'b1, 8'h00, q);
      chk("deselect", 8'h20, q);
    end
    cmd(1'b0, 8'hBB);
    cmd(1'b0, 8'h7E);
    rd(1'b1);
    for (int i = 0; i < 3; i++) begin
      rd(1'b1);
      chk("read", exp_rd[i], q);
    end
    for (int i = 0; i < 2; i++) begin
      cmd(1'b0, 8'h3F ^ i[7:0]);
      rd(1'b0);
      chk("held", i ? 8'h00 : 8'h20, q);
      pulse(1'b1, i ? 8'h1C : 8'h19);
      rd(1'b0);
      chk("onoff", i ? 8'h20 : 8'h00, q);
      if (i == 0) begin
        pulse(1'b1, 8'h1A);
        chk("seg_fwd", 8'h05, {5'h0, seg[63], seg[62], seg[0]});
        seg_order = 1'b0;
        pulse(1'b1, 8'h1B);
        chk("seg_rev", 8'h02, {5'h0, seg[63], seg[1], seg[0]});
      end
    end
    chk("blank", 8'h00, {7'h0, seg !== 64'h0});
    end_of_test();
  end
endmodule : lcd_column_driver_host_port_bench
bind lcd_col_drv lcd_col_drv_chk #(.COL_NUM(COL_NUM), .PAGE_NUM(PAGE_NUM))
  u_chk (.clock_in(clock_in), .arst_n_in(arst_n_in),
  .chip_select_first_low_n_in(chip_select_first_low_n_in),
  .chip_select_second_low_n_in(chip_select_second_low_n_in),
  .chip_select_third_high_in(chip_select_third_high_in),
  .register_select_in(register_select_in), .read_write_in(read_write_in),
  .strobe_in(strobe_in), .data_out(data_out), .data_oe_out(data_oe_out),
  .reset_input_low_n_in(reset_input_low_n_in),
  .line_shift_pulse_in(line_shift_pulse_in), .frame_sync_in(frame_sync_in),
  .segment_out(segment_out), .row_out(row_out));
`default_nettype wire
